// ---- dv/ctgc_counter_chk.sv ----
// Port-level checks for one counter
`include "ctgc_consts.svh"
`default_nettype none
module ctgc_counter_chk #(
  parameter int IDX = 0
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [4:0]  freqIn,
  input wire logic [4:0]  countInputPin,
  input wire logic [4:0]  gateInputPin,
  input wire logic        lowerCounterTerminal,
  input wire logic        terminalEvent,
  input wire logic        counterOutPin
);
  logic [15:0] modeShadow;
  logic [3:0]  quietCnt;
  logic [3:0]  idleCnt;
  logic        disarmedSw;
  wire logic   wrDone = psel && penable && pready && pwrite;
  wire logic   wrAny  = psel && pwrite;
  // Mode as software last wrote it
  always_ff @(posedge clk) begin
    if (!rst_n) modeShadow <= `CTGC_MODE_RESET;
    else if (wrDone && paddr == `CTGC_ADDR_MODE) modeShadow <= pwdata[15:0];
  end
  // Software arm state
  always_ff @(posedge clk) begin
    if (!rst_n) disarmedSw <= 1'b1;
    else if (wrDone && paddr == `CTGC_ADDR_COMMAND) begin
      if (pwdata[`CTGC_CMD_ARM] || pwdata[`CTGC_CMD_PRESET_ARM]) disarmedSw <= 1'b0;
      else if (pwdata[`CTGC_CMD_DISARM]) disarmedSw <= 1'b1;
    end
  end
  // Any write may be a step or preset, so it restarts both quiet counts
  always_ff @(posedge clk) begin
    if (!rst_n || wrAny || modeShadow[15:13] != 3'h4 || gateInputPin[IDX]) quietCnt <= 4'h0;
    else if (quietCnt != 4'hf) quietCnt <= quietCnt + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || wrAny || !disarmedSw || terminalEvent) idleCnt <= 4'h0;
    else if (idleCnt != 4'hf) idleCnt <= idleCnt + 4'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property ((s_done ##0
    (paddr > `CTGC_ADDR_COUNT || paddr[1:0] != 2'b00)) |-> pslverr)
    else $error("unmapped access not refused");
  a_err_zero: assert property ((s_done ##0 (pslverr && !pwrite)) |-> prdata == 32'h0)
    else $error("refused read not zero");
  a_mode_read: assert property (
    (s_done ##0 (!pwrite && paddr == `CTGC_ADDR_MODE)) |-> prdata == {16'h0, modeShadow})
    else $error("mode readback wrong");
  a_reset_quiet: assert property ($rose(rst_n) |-> !terminalEvent && !counterOutPin)
    else $error("outputs active after reset");
  a_toggle_near: assert property ($changed(counterOutPin) |->
    terminalEvent || $past(terminalEvent) || $past(terminalEvent, 2))
    else $error("toggle away from terminal event");
  a_gated_quiet: assert property (quietCnt > 4'h8 |-> !$rose(terminalEvent))
    else $error("terminal event while gated off");
  a_idle_quiet: assert property (idleCnt > 4'h3 |-> !terminalEvent)
    else $error("terminal event while disarmed");
endmodule : ctgc_counter_chk
`default_nettype wire

// ---- dv/ctgc_far_side.sv ----
// Far-side model: count source pulses and gate level
`default_nettype none
module ctgc_far_side (
  output logic [4:0] srcPin,
  output logic [4:0] gatePin,
  input  wire logic  clk
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    srcPin  = 5'h00;
    gatePin = 5'h00;
  end
  // Each level held three clocks, above the two-clock minimum the synchroniser needs
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clk);
      srcPin[0] <= 1'b1;
      repeat (3) @(posedge clk);
      srcPin[0] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : pulses
  // Gate settles through its synchroniser before counting resumes
  task automatic setGate(input logic v);
    @(posedge clk);
    gatePin[0] <= v;
    repeat (6) @(posedge clk);
  endtask : setGate
endmodule : ctgc_far_side
`default_nettype wire

// ---- dv/tb.sv ----
// Testbench for one counter: APB master, far-side model, checks
`include "ctgc_consts.svh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic        pready, pslverr, terminalEvent, counterOutPin, tePrev = 1'b0, outExp = 1'b0;
  logic [4:0]  freqIn = 5'h00, srcPin, gatePin;
  logic [15:0] lfsrState = 16'h3bbc;
  int          err_count = 0, samples_checked = 0, rises = 0;
  always #50 clk = ~clk;
  // Lower counter stand-in: the far-side source pulses double as the cascade input
  ctgc_counter #(.IDX(0)) ctgc_counter_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .freqIn(freqIn), .countInputPin(srcPin),
    .gateInputPin(gatePin), .lowerCounterTerminal(srcPin[0]), .terminalEvent(terminalEvent),
    .counterOutPin(counterOutPin));
  ctgc_far_side ctgc_far_side_inst (.srcPin(srcPin), .gatePin(gatePin), .clk(clk));
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsrNext
  function automatic logic [15:0] modeVal(input logic [2:0] g, input logic rep, up, bcd);
    return {g, 1'b0, 4'h5, 2'b00, rep, bcd, up, 3'b000};
  endfunction : modeVal
  // Preset that reaches the terminal event after k source edges
  function automatic logic [15:0] presetFor(input int k, input logic up, bcd);
    if (!up) return 16'(k);
    return bcd ? 16'h9999 - 16'(k - 1) : 16'h0000 - 16'(k);
  endfunction : presetFor
  // Unselected oscillator inputs toggle at random; they must not disturb counting
  always @(posedge clk) begin
    lfsrState <= lfsrNext(lfsrState);
    freqIn    <= lfsrState[4:0];
  end
  // Count rising edges of the terminal output
  always @(posedge clk) begin
    if (terminalEvent === 1'b1 && tePrev !== 1'b1) rises++;
    tePrev <= terminalEvent;
  end
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask : chk
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(a, 1'b1, d, r, e);
  endtask : wr
  task automatic cmd(input int b);
    wr(`CTGC_ADDR_COMMAND, 32'h1 << b);
  endtask : cmd
  task automatic settle(input int n, input logic t);
    ctgc_far_side_inst.pulses(n);
    repeat (8) @(posedge clk);
    outExp ^= t;
    chk("toggle", 32'(outExp), 32'(counterOutPin));
  endtask : settle
  task automatic runCase(input logic [15:0] m, p, input int edges, nRise, nTog);
    cmd(`CTGC_CMD_DISARM);
    wr(`CTGC_ADDR_MODE, 32'(m));
    wr(`CTGC_ADDR_PRESET, 32'(p));
    cmd(`CTGC_CMD_PRESET_ARM);
    rises = 0;
    settle(edges, nTog[0]);
    chk("rises", nRise, rises);
    $display("case mode %h preset %h done", m, p);
  endtask : runCase
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    int k;
    logic [31:0] r;
    logic e;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(`CTGC_ADDR_MODE, 1'b0, 32'h0, r, e);
    chk("mode", 32'h0800, r);
    apb(12'h040, 1'b0, 32'h0, r, e);
    chk("pslverr", 32'h1, 32'(e));
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      k = 2 + int'(lfsrState % 4);
      runCase(modeVal(3'h0, 1'b1, i[0], i[1]), presetFor(k, i[0], i[1]),
              3 * k + 1, 3, 3);
    end
    runCase(modeVal(3'h0, 1'b1, 1'b0, 1'b0) | 16'h1a00, 16'h0003, 7, 2, 2);
    runCase(modeVal(3'h0, 1'b0, 1'b0, 1'b0), 16'h0003, 10, 1, 1);
    runCase(modeVal(3'h0, 1'b1, 1'b0, 1'b0), 16'h0001, 4, 1, 3);
    chk("held", 32'h1, 32'(terminalEvent));
    wr(`CTGC_ADDR_PRESET, 32'h5);
    cmd(`CTGC_CMD_DISARM);
    settle(2, 1'b0);
    chk("ended", 32'h0, 32'(terminalEvent));
    rises = 0;
    settle(3, 1'b0);
    chk("idle", 32'h0, rises);
    $display("disarm test done");
    for (int g = 4; g < 6; g++) begin
      ctgc_far_side_inst.setGate(g == 5);
      runCase(modeVal(3'(g), 1'b1, 1'b0, 1'b0), 16'h0003, 6, 0, 0);
      ctgc_far_side_inst.setGate(g == 4);
      settle(4, 1'b1);
      chk("gated", 32'h1, rises);
    end
    // Retrigger: first qualified edge reloads, gate edge saves the count
    runCase(modeVal(3'h4, 1'b1, 1'b0, 1'b0) | 16'h0080, 16'h0003, 2, 0, 0);
    ctgc_far_side_inst.setGate(1'b1);
    settle(3, 1'b0);
    chk("retrig", 32'h0, rises);
    apb(`CTGC_ADDR_CAPTURE, 1'b0, 32'h0, r, e);
    chk("capture", 32'h3, r);
    $display("retrigger test done");
    // Step commands alone walk the counter through commit and terminal
    runCase(modeVal(3'h0, 1'b1, 1'b1, 1'b0), 16'hfffe, 0, 0, 0);
    repeat (3) cmd(`CTGC_CMD_STEP);
    settle(0, 1'b1);
    chk("stepped", 32'h1, rises);
    $display("step test done");
    summarize();
  end
  // Watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("timeout");
    summarize();
  end
endmodule : tb
bind ctgc_counter ctgc_counter_chk #(.IDX(IDX)) ctgc_counter_chk_inst (.clk(clk),
  .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .freqIn(freqIn),
  .countInputPin(countInputPin), .gateInputPin(gateInputPin),
  .lowerCounterTerminal(lowerCounterTerminal), .terminalEvent(terminalEvent),
  .counterOutPin(counterOutPin));
`default_nettype wire

// ---- logic/ctgc_consts.svh ----
// Constants for the counter gating and control block
`ifndef CTGC_CONSTS_SVH
`define CTGC_CONSTS_SVH
`define CTGC_ADDR_MODE      12'h000
`define CTGC_ADDR_PRESET    12'h004
`define CTGC_ADDR_CAPTURE   12'h008
`define CTGC_ADDR_COMMAND   12'h00c
`define CTGC_ADDR_STATUS    12'h010
`define CTGC_ADDR_COUNT     12'h014
`define CTGC_MODE_RESET     16'h0800
`define CTGC_BIT_DIR        3
`define CTGC_BIT_BCD        4
`define CTGC_BIT_REPEAT     5
`define CTGC_BIT_RELOAD     6
`define CTGC_BIT_SPECIAL    7
`define CTGC_SRC_LO         8
`define CTGC_SRC_HI         11
`define CTGC_BIT_POL        12
`define CTGC_GATE_LO        13
`define CTGC_GATE_HI        15
`define CTGC_CMD_ARM        0
`define CTGC_CMD_DISARM     1
`define CTGC_CMD_PRESET     2
`define CTGC_CMD_PRESET_ARM 3
`define CTGC_CMD_STEP       4
`define CTGC_CMD_SAVE       5
`endif

// ---- logic/ctgc_counter.sv ----
// One counter of the timer: source and gate selection, counting, reload and APB registers
`include "ctgc_consts.svh"
`default_nettype none
// Contract
// RL1: Each terminal event reloads counter from preset or capture register.
// RL2: Cycle before terminal event commits; retrigger or preset cannot postpone it.
// RL3: Preset command before terminal forces it; during terminal ends it at once.
// RL4: Terminal event always counts next source edge, even disarmed or gated off.
// RL5: Disarm or stop at terminal takes effect only after terminal ends.
// RL6: Near-terminal reload value makes every count re-enter terminal event.
// RL7: With near-terminal contents, preset or step commands act like source pulse.
// RL8: Direction and BCD bits are independent, combinable with everything.
// RL9: Repeat bit one keeps counting; zero self-disarms after one cycle.
// RL10: Self-disarm still counts the edge that ends the terminal event.
// RL11: Reload bit zero uses preset; one uses gate level or alternation.
// RL12: Retrigger edge saves count to capture; next qualified edge loads preset.
// RL13: Preset or step command after retrigger edge acts as that source edge.
// RL14: With gating, special bit enables retriggering on active gate edges.
// RL15: Without gating, special bit lets gate level choose reload register.
// RL16: Polarity bit selects rising or falling edges of every source.
// RL17: Four-bit field picks one of sixteen count sources.
// RL18: Counter five terminal output cascades into counter one.
// RL19: Gating code zero counts whenever armed; others follow gate configuration.
// RL20: Codes 100/101 own gate level; 010/011 neighbour gates, wrapping.
// RL21: Edge codes start on gate edge, run to terminal; repeat restarts.
// RL22: Code 001 gates with lower counter pulse terminal output.
// RL23: Mode register resets to 0800 hex.
// RL24: Arm commands reset alternation so first reload comes from capture.
// RL25: Code 110 triggers on rising gate edge, 111 on falling.
// RL26: Source and gate inputs are synchronised and edge-detected.
module ctgc_counter #(
  parameter int IDX = 0
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  freqIn,
  input  wire logic [4:0]  countInputPin,
  input  wire logic [4:0]  gateInputPin,
  input  wire logic        lowerCounterTerminal,
  output logic             terminalEvent,
  output logic             counterOutPin
);
  localparam int UP = (IDX + 1) % 5;
  localparam int DN = (IDX + 4) % 5;

  logic [15:0] modeReg;
  logic [15:0] presetReg;
  logic [15:0] captureReg;
  logic [15:0] countReg;
  logic        armedReg;
  logic        termReg;
  logic        toggleReg;
  logic        commitReg;
  logic        retrigReg;
  logic        altReg;
  logic        edgeRunReg;
  logic        cycleTcReg;
  logic [15:0] syncAReg;
  logic [15:0] syncBReg;
  logic [15:0] syncCReg;
  logic        gateARegs;
  logic        gateBReg;
  logic        gateCReg;

  // Decoded mode fields
  ctgc_pkg::ctgc_gating_t gating;
  logic       dirUp;
  logic       bcd;
  logic       repeatOn;
  logic       reloadSel;
  logic       special;
  logic [3:0] srcSel;
  logic       pol;
  assign gating    = ctgc_pkg::ctgc_gating_t'(modeReg[`CTGC_GATE_HI:`CTGC_GATE_LO]);
  assign dirUp     = modeReg[`CTGC_BIT_DIR];
  assign bcd       = modeReg[`CTGC_BIT_BCD];
  assign repeatOn  = modeReg[`CTGC_BIT_REPEAT];
  assign reloadSel = modeReg[`CTGC_BIT_RELOAD];
  assign special   = modeReg[`CTGC_BIT_SPECIAL];
  assign srcSel    = modeReg[`CTGC_SRC_HI:`CTGC_SRC_LO];
  assign pol       = modeReg[`CTGC_BIT_POL];

  // Two-flop synchronisers on all sixteen raw inputs, third flop for edges [RL26]
  logic [15:0] rawIn;
  assign rawIn = {lowerCounterTerminal, gateInputPin, countInputPin, freqIn};
  always_ff @(posedge clk) begin
    syncAReg <= rawIn;
    syncBReg <= syncAReg;
    syncCReg <= syncBReg;
  end

  // Source mux and polarity; index 15 is the cascade from the lower counter [RL17] [RL18]
  logic srcEdge;
  assign srcEdge = pol ? (syncCReg[srcSel] & ~syncBReg[srcSel])
                       : (~syncCReg[srcSel] & syncBReg[srcSel]); // [RL16]

  // Gate signal selection; neighbours wrap between counters 1 and 5 [RL20] [RL22]
  function automatic logic gate_pick(input logic [2:0] code, input logic [15:0] s);
    case (code)
      3'h1:    gate_pick = s[15];
      3'h2:    gate_pick = s[10 + UP];
      3'h3:    gate_pick = s[10 + DN];
      default: gate_pick = s[10 + IDX];
    endcase
  endfunction : gate_pick
  logic gateNow;
  logic gatePrev;
  always_ff @(posedge clk) begin
    gateARegs <= gate_pick(modeReg[15:13], syncBReg);
    gateBReg  <= gateARegs;
    gateCReg  <= gateBReg;
  end
  assign gateNow  = gateBReg;
  assign gatePrev = gateCReg;

  // Level gating and active-going edge
  logic gateActive;
  logic gateEdge;
  always_comb begin
    case (gating)
      ctgc_pkg::CTGC_GATE_NONE: gateActive = 1'b1;                    // [RL19]
      ctgc_pkg::CTGC_GATE_LOW:  gateActive = ~gateNow;                // [RL20]
      ctgc_pkg::CTGC_GATE_RISE,
      ctgc_pkg::CTGC_GATE_FALL: gateActive = edgeRunReg;              // [RL21]
      default:                  gateActive = gateNow;
    endcase
  end
  assign gateEdge = (gating == ctgc_pkg::CTGC_GATE_LOW || gating == ctgc_pkg::CTGC_GATE_FALL)
                    ? (gatePrev & ~gateNow) : (~gatePrev & gateNow);  // [RL25]

  // APB decode; zero wait states
  logic        wrEn;
  logic [5:0]  cmd;
  assign wrEn = psel & penable & pwrite;
  assign cmd  = (wrEn && paddr == `CTGC_ADDR_COMMAND) ? pwdata[5:0] : 6'h00;
  logic cmdArm;
  logic cmdDisarm;
  logic cmdPreset;
  logic cmdPresetArm;
  logic cmdStep;
  assign cmdArm       = cmd[`CTGC_CMD_ARM];
  assign cmdDisarm    = cmd[`CTGC_CMD_DISARM];
  assign cmdPreset    = cmd[`CTGC_CMD_PRESET];
  assign cmdPresetArm = cmd[`CTGC_CMD_PRESET_ARM];
  assign cmdStep      = cmd[`CTGC_CMD_STEP];

  // Count step in binary or BCD, up or down [RL8]
  function automatic logic [15:0] step_val(input logic [15:0] v, input logic up,
                                            input logic dec);
    logic [15:0] r;
    logic        carry;
    r = v;
    carry = 1'b1;
    if (!dec) begin
      step_val = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (carry) begin
          if (up) begin
            r[i*4 +: 4] = (v[i*4 +: 4] == 4'h9) ? 4'h0 : v[i*4 +: 4] + 4'h1;
            carry = (v[i*4 +: 4] == 4'h9);
          end else begin
            r[i*4 +: 4] = (v[i*4 +: 4] == 4'h0) ? 4'h9 : v[i*4 +: 4] - 4'h1;
            carry = (v[i*4 +: 4] == 4'h0);
          end
        end
      end
      step_val = r;
    end
  endfunction : step_val

  // Near-terminal contents: next count reaches the terminal event [RL6]
  logic nearTerm;
  assign nearTerm = dirUp ? (countReg == (bcd ? 16'h9999 : 16'hffff)) : (countReg == 16'h0001);

  // Effective count pulse: qualified edge, forced edge in terminal, or command
  logic qualEdge;
  logic swPulse;
  logic countPulse;
  logic fromCapture;
  logic [15:0] reloadVal;
  assign qualEdge   = srcEdge & ((armedReg & gateActive) | termReg);       // [RL4]
  assign swPulse    = cmdPreset | cmdPresetArm | cmdStep;
  assign countPulse = qualEdge | cmdStep | ((commitReg | termReg) & swPulse); // [RL3] [RL7] [RL13]
  // Reload source selection [RL11] [RL15]
  assign fromCapture = reloadSel & ((gating == ctgc_pkg::CTGC_GATE_NONE && special)
                                      ? gateNow : altReg);
  assign reloadVal   = fromCapture ? captureReg : presetReg;               // [RL1]

  // Mode register, loaded only by software [RL23]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      modeReg <= `CTGC_MODE_RESET;
    end else if (wrEn && paddr == `CTGC_ADDR_MODE) begin
      modeReg <= pwdata[15:0];
    end
  end

  // Preset register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      presetReg <= 16'h0000;
    end else if (wrEn && paddr == `CTGC_ADDR_PRESET) begin
      presetReg <= pwdata[15:0];
    end
  end

  // Capture register: software write, save command or retrigger edge [RL12]
  logic retrigOn;
  assign retrigOn = (gating != ctgc_pkg::CTGC_GATE_NONE) & special;         // [RL14]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      captureReg <= 16'h0000;
    end else if (retrigOn && gateEdge && armedReg) begin
      captureReg <= countReg;                                              // [RL12]
    end else if (cmd[`CTGC_CMD_SAVE]) begin
      captureReg <= countReg;
    end else if (wrEn && paddr == `CTGC_ADDR_CAPTURE) begin
      captureReg <= pwdata[15:0];
    end
  end

  // Retrigger pending: the next qualified edge or command loads preset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      retrigReg <= 1'b0;
    end else if (retrigOn && gateEdge && armedReg && !commitReg && !termReg) begin
      retrigReg <= 1'b1;                                                   // [RL2]
    end else if (qualEdge || swPulse) begin
      retrigReg <= 1'b0;                                                   // [RL13]
    end
  end

  // Edge-gated run window, opened by the trigger edge, closed after the full cycle
  logic needTwo;
  assign needTwo = reloadSel & ~(gating == ctgc_pkg::CTGC_GATE_NONE && special);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      edgeRunReg <= 1'b0;
    end else if (gateEdge && armedReg) begin
      edgeRunReg <= 1'b1;                                                  // [RL21]
    end else if (termReg && countPulse && (!needTwo || cycleTcReg)) begin
      edgeRunReg <= 1'b0;
    end
  end

  // Counter value, commitment and terminal state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      countReg  <= 16'h0000;
      termReg   <= 1'b0;
      commitReg <= 1'b0;
    end else begin
      if (countPulse && (commitReg || (termReg && nearTerm))) begin
        countReg  <= reloadVal;                                            // [RL1] [RL6]
        termReg   <= 1'b1;
        commitReg <= 1'b0;
      end else if (termReg && (countPulse || cmdPreset || cmdPresetArm)) begin
        countReg  <= step_val(countReg, dirUp, bcd);                       // [RL3] [RL4]
        termReg   <= 1'b0;
      end else if ((countPulse && retrigReg) || cmdPreset || cmdPresetArm) begin
        countReg  <= fromCapture && !retrigReg ? captureReg : presetReg;   // [RL12] [RL13]
      end else if (countPulse) begin
        countReg  <= step_val(countReg, dirUp, bcd);
      end
      if (!termReg && !countPulse) begin
        commitReg <= nearTerm & ~retrigReg;                                // [RL2]
      end else if (countPulse && !termReg && !commitReg) begin
        commitReg <= (step_val(countReg, dirUp, bcd) ==
                      (dirUp ? (bcd ? 16'h9999 : 16'hffff) : 16'h0001));
      end
    end
  end

  // Alternation of reload source; arming resets it [RL24]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      altReg <= 1'b1;
    end else if (cmdArm || cmdPresetArm) begin
      altReg <= 1'b1;
    end else if (countPulse && commitReg) begin
      altReg <= ~altReg;
    end
  end

  // Count of terminal events within one cycle, for self-disarm
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cycleTcReg <= 1'b0;
    end else if (cmdArm || cmdPresetArm) begin
      cycleTcReg <= 1'b0;
    end else if (termReg && countPulse) begin
      cycleTcReg <= ~cycleTcReg;
    end
  end

  // Arming; disarm held off until terminal ends [RL5] [RL9] [RL10]
  logic pendDisarmReg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      armedReg      <= 1'b0;
      pendDisarmReg <= 1'b0;
    end else if (cmdArm || cmdPresetArm) begin
      armedReg      <= 1'b1;
      pendDisarmReg <= 1'b0;
    end else if (termReg) begin
      if (cmdDisarm || (!repeatOn && (!needTwo || cycleTcReg))) begin
        pendDisarmReg <= 1'b1;                                             // [RL5]
      end
      if (countPulse && (pendDisarmReg || cmdDisarm ||
                         (!repeatOn && (!needTwo || cycleTcReg)))) begin
        armedReg      <= 1'b0;                                             // [RL10]
        pendDisarmReg <= 1'b0;
      end
    end else if (cmdDisarm) begin
      armedReg <= 1'b0;
    end
  end

  // Outputs: pulse form and toggled form, toggled on terminal trailing edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      toggleReg     <= 1'b0;
      terminalEvent <= 1'b0;
      counterOutPin <= 1'b0;
    end else begin
      if (termReg && countPulse) begin
        toggleReg <= ~toggleReg;                                           // [RL6]
      end
      terminalEvent <= termReg;
      counterOutPin <= toggleReg;
    end
  end

  // APB read data and response
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & (paddr > `CTGC_ADDR_COUNT | paddr[1:0] != 2'h0);
      case (paddr)
        `CTGC_ADDR_MODE:    prdata <= {16'h0000, modeReg};
        `CTGC_ADDR_PRESET:  prdata <= {16'h0000, presetReg};
        `CTGC_ADDR_CAPTURE: prdata <= {16'h0000, captureReg};
        `CTGC_ADDR_STATUS:  prdata <= {27'h0, retrigReg, commitReg, toggleReg, termReg, armedReg};
        `CTGC_ADDR_COUNT:   prdata <= {16'h0000, countReg};
        default:            prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : ctgc_counter
`default_nettype wire

// ---- logic/ctgc_pkg.sv ----
// Types for the counter gating and control block
`default_nettype none
package ctgc_pkg;
  typedef enum logic [2:0] {
    CTGC_GATE_NONE  = 3'h0,
    CTGC_GATE_CASC  = 3'h1,
    CTGC_GATE_UPPER = 3'h2,
    CTGC_GATE_LOWER = 3'h3,
    CTGC_GATE_HIGH  = 3'h4,
    CTGC_GATE_LOW   = 3'h5,
    CTGC_GATE_RISE  = 3'h6,
    CTGC_GATE_FALL  = 3'h7
  } ctgc_gating_t;
  typedef enum logic [1:0] {
    CTGC_ST_IDLE  = 2'b00,
    CTGC_ST_RUN   = 2'b01,
    CTGC_ST_TERM  = 2'b11
  } ctgc_state_t;
endpackage : ctgc_pkg
`default_nettype wire
